// ==== rtl/ldh_pkg.sv ====
package ldh_pkg;
  // ------------------------------------------------------------
  // Link command codes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_POKE = 8'h00;
  localparam logic [7:0] CMD_PEEK = 8'h01;
  localparam int POKE_BYTES = 8;
  localparam int PEEK_BYTES = 4;
  localparam int NUM_LINKS = 4;

  // ------------------------------------------------------------
  // Memory map and boot addresses
  // ------------------------------------------------------------
  localparam logic [31:0] USER_MEMORY_BASE = 32'h80000070;
  localparam logic [31:0] ROM_BOOT_ADDR = 32'h7ffffffe;
  localparam logic [31:0] FAULT_IPTR_STEP = 32'h00000002;
  localparam logic [31:0] HALT_IPTR_STEP = 32'h00000001;
  localparam int REFRESH_BURST = 8;
  localparam int MEMCFG_CYCLES = 36;

  // ------------------------------------------------------------
  // APB register offsets of the host controller
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_KIND_LO = 1;
  localparam int CTRL_LINK_LO = 3;
  localparam int CTRL_HALT_BIT = 5;
  localparam int CTRL_RST_BIT = 6;
  localparam int CTRL_BOOTSEL_BIT = 7;
  localparam int CTRL_LOADLEN_LO = 8;
  localparam int CTRL_CHAIN_BIT = 16;
  localparam logic [1:0] KIND_POKE = 2'h0;
  localparam logic [1:0] KIND_PEEK = 2'h1;
  localparam logic [1:0] KIND_LOAD = 2'h2;
endpackage : ldh_pkg

// ==== rtl/ldh_if.sv ====
interface ldh_if;
  // Byte stream to the device, per link
  logic [3:0] rx_valid;
  logic [7:0] rx_byte [4];
  logic [3:0] rx_ready;
  // Byte stream from the device, per link
  logic [3:0] tx_valid;
  logic [7:0] tx_byte [4];
  logic [3:0] tx_ready;
  // Board level signals
  logic proc_reset;
  logic inspect_halt;
  logic boot_source_select;
  logic chained_fault_input;
  logic fault_out;
  logic halted;
  logic links_idle;

  modport dev (
    input rx_valid, rx_byte, tx_ready, proc_reset, inspect_halt,
    input boot_source_select, chained_fault_input,
    output rx_ready, tx_valid, tx_byte, fault_out, halted, links_idle
  );
  modport host (
    output rx_valid, rx_byte, tx_ready, proc_reset, inspect_halt,
    output boot_source_select, chained_fault_input,
    input rx_ready, tx_valid, tx_byte, fault_out, halted, links_idle
  );
endinterface : ldh_if

// ==== rtl/ldh_device.sv ====
module ldh_device #(
  parameter int MEM_WORDS = 1024,
  parameter int SLICE_CYCLES = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  ldh_if.dev lnk,
  // Processor side event inputs
  input wire logic [4:0] fault_events,
  input wire logic set_stop_on_fault,
  input wire logic test_clear,
  input wire logic preempt_begin,
  input wire logic preempt_end,
  input wire logic deschedule,
  output logic running,
  output logic stop_on_fault_flag,
  output logic fault_flag,
  output logic [31:0] iptr,
  output logic [31:0] wptr,
  output logic [31:0] areg,
  output logic [31:0] breg,
  output logic [31:0] creg,
  output logic [5:0] memcfg_count,
  output logic refresh_on
);
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    LDH_CFG, LDH_WAIT, LDH_GATHER, LDH_SEND, LDH_LOAD, LDH_RUN,
    LDH_HALTING, LDH_HALTED
  } ldh_state_e;
  ldh_state_e state_r;
  logic [31:0] mem_r [MEM_WORDS];
  logic [1:0] link_r;
  logic [7:0] cmd_r;
  logic [3:0] cnt_r;
  logic [31:0] addr_r;
  logic [31:0] data_r;
  logic [31:0] load_left_r;
  logic [31:0] load_ptr_r;
  logic [1:0] rst_s_r, halt_s_r, boot_s_r, err_s_r;
  logic rst_q_r, halt_q_r;
  logic fault_r, stop_r, fault_sv_r, stop_sv_r;
  logic [31:0] slice_r;
  logic [3:0] rx_v;
  logic [1:0] tx_bytes_r;
  logic [3:0] rdy_r, txv_r;
  logic [7:0] txb_r;
  logic [31:0] cfg_r;
  logic rx_hit;
  logic [7:0] rx_b;
  logic fault_new;

  function automatic int widx(input logic [31:0] a);
    return int'(a[11:2]) % MEM_WORDS;
  endfunction : widx

  // Incoming byte on the selected link
  always_comb begin
    // Same clock as the sender, so valid is used directly
    rx_v = lnk.rx_valid;
    rx_hit = rx_v[link_r] & rdy_r[link_r];
    rx_b = lnk.rx_byte[link_r];
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_s_r <= 2'h0;
      halt_s_r <= 2'h0;
      boot_s_r <= 2'h0;
      err_s_r <= 2'h0;
    end else begin
      rst_s_r <= {rst_s_r[0], lnk.proc_reset};
      halt_s_r <= {halt_s_r[0], lnk.inspect_halt};
      boot_s_r <= {boot_s_r[0], lnk.boot_source_select};
      err_s_r <= {err_s_r[0], lnk.chained_fault_input};
    end
  end

  // Edge history of synced controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_q_r <= 1'b0;
      halt_q_r <= 1'b0;
    end else begin
      rst_q_r <= rst_s_r[1];
      halt_q_r <= halt_s_r[1];
    end
  end

  // ------------------------------------------------------------
  // Fault flags, not touched by processor reset
  // ------------------------------------------------------------
  assign fault_new = |fault_events;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_r <= 1'b0;
      stop_r <= 1'b0;
      fault_sv_r <= 1'b0;
      stop_sv_r <= 1'b0;
    end else begin
      if (preempt_begin) begin
        fault_sv_r <= fault_r;
        stop_sv_r <= stop_r;
      end
      if (preempt_end) begin
        fault_r <= fault_sv_r | fault_new;
        stop_r <= stop_sv_r;
      end else begin
        if (fault_new) fault_r <= 1'b1;
        else if (test_clear) fault_r <= 1'b0;
        if (set_stop_on_fault) stop_r <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Link handshake registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_r <= 4'h0;
    end else if (rx_hit) begin
      rdy_r <= 4'h0;
    end else if (state_r == LDH_WAIT) begin
      rdy_r <= 4'hf;
    end else if (state_r == LDH_GATHER || state_r == LDH_LOAD ||
                 state_r == LDH_HALTING) begin
      rdy_r <= 4'h0;
      rdy_r[link_r] <= 1'b1;
    end else begin
      rdy_r <= 4'h0;
    end
  end

  // ------------------------------------------------------------
  // Main sequencer
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= LDH_CFG;
      link_r <= 2'h0;
      cmd_r <= 8'h00;
      cnt_r <= 4'h0;
      addr_r <= 32'h0;
      data_r <= 32'h0;
      load_left_r <= 32'h0;
      load_ptr_r <= 32'h0;
      txv_r <= 4'h0;
      txb_r <= 8'h00;
      tx_bytes_r <= 2'h0;
      slice_r <= 32'h0;
      memcfg_count <= 6'h0;
      cfg_r <= 32'h0;
      iptr <= 32'h0;
      wptr <= 32'h0;
      areg <= 32'h0;
      breg <= 32'h0;
      creg <= 32'h0;
    end else if (rst_q_r && !rst_s_r[1]) begin
      // Reset release
      if (halt_s_r[1]) begin
        state_r <= LDH_HALTED;
        areg <= iptr;
        breg <= wptr;
      end else begin
        state_r <= LDH_CFG;
        memcfg_count <= 6'h0;
      end
    end else if (rst_s_r[1]) begin
      txv_r <= 4'h0;
    end else begin
      unique case (state_r)
        LDH_CFG: begin
          memcfg_count <= memcfg_count + 6'h1;
          if (32'(memcfg_count) == ldh_pkg::MEMCFG_CYCLES +
              ldh_pkg::REFRESH_BURST - 1) begin
            cfg_r <= 32'h1;
            state_r <= boot_s_r[1] ? LDH_RUN : LDH_WAIT;
            iptr <= boot_s_r[1] ? ldh_pkg::ROM_BOOT_ADDR
                               : ldh_pkg::USER_MEMORY_BASE;
            wptr <= ldh_pkg::USER_MEMORY_BASE;
          end
        end
        LDH_HALTED: begin
          if (halt_q_r && !halt_s_r[1]) begin
            state_r <= boot_s_r[1] ? LDH_RUN : LDH_WAIT;
            iptr <= boot_s_r[1] ? ldh_pkg::ROM_BOOT_ADDR
                               : ldh_pkg::USER_MEMORY_BASE;
            wptr <= ldh_pkg::USER_MEMORY_BASE;
          end
        end
        LDH_WAIT: begin
          for (int i = 0; i < ldh_pkg::NUM_LINKS; i++) begin
            if (rx_v[i] && rdy_r[i]) begin
              link_r <= 2'(i);
              creg <= 32'(i);
              cmd_r <= lnk.rx_byte[i];
              cnt_r <= 4'h0;
              if (lnk.rx_byte[i] == ldh_pkg::CMD_POKE ||
                  lnk.rx_byte[i] == ldh_pkg::CMD_PEEK) begin
                state_r <= LDH_GATHER;
              end else begin
                load_left_r <= 32'(lnk.rx_byte[i]);
                load_ptr_r <= ldh_pkg::USER_MEMORY_BASE;
                state_r <= LDH_LOAD;
              end
            end
          end
        end
        LDH_GATHER: if (rx_hit) begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r < 4'h4) addr_r <= {rx_b, addr_r[31:8]};
          else data_r <= {rx_b, data_r[31:8]};
          if (cmd_r == ldh_pkg::CMD_PEEK && cnt_r == 4'h3) begin
            data_r <= mem_r[widx({rx_b, addr_r[31:8]})];
            tx_bytes_r <= 2'h0;
            state_r <= LDH_SEND;
          end else if (32'(cnt_r) == ldh_pkg::POKE_BYTES - 1) begin
            state_r <= LDH_WAIT;
          end
        end
        LDH_SEND: begin
          if (txv_r[link_r] && lnk.tx_ready[link_r]) begin
            txv_r <= 4'h0;
            data_r <= {8'h00, data_r[31:8]};
            tx_bytes_r <= tx_bytes_r + 2'h1;
            if (tx_bytes_r == 2'h3) state_r <= LDH_WAIT;
          end else begin
            txv_r[link_r] <= 1'b1;
            txb_r <= data_r[7:0];
          end
        end
        LDH_LOAD: if (rx_hit) begin
          load_ptr_r <= load_ptr_r + 32'h1;
          load_left_r <= load_left_r - 32'h1;
          if (load_left_r == 32'h1) begin
            iptr <= ldh_pkg::USER_MEMORY_BASE;
            wptr <= (load_ptr_r + 32'h4) & ~32'h3;
            state_r <= LDH_RUN;
          end
        end
        LDH_RUN: begin
          slice_r <= slice_r + 32'h1;
          if (stop_r && fault_new && !fault_r) begin
            iptr <= iptr + ldh_pkg::FAULT_IPTR_STEP;
            state_r <= LDH_HALTING;
          end else if (halt_s_r[1] && (deschedule ||
                       slice_r >= 32'(3 * SLICE_CYCLES))) begin
            iptr <= iptr + ldh_pkg::HALT_IPTR_STEP;
            state_r <= LDH_HALTING;
          end
          if (!halt_s_r[1]) slice_r <= 32'h0;
        end
        LDH_HALTING: begin
          txv_r <= 4'h0;
          areg <= iptr;
          breg <= wptr;
          state_r <= LDH_HALTED;
        end
        default: state_r <= LDH_CFG;
      endcase
    end
  end

  // Memory writes for poke and load
  always_ff @(posedge pclk) begin
    if (state_r == LDH_GATHER && rx_hit && cmd_r == ldh_pkg::CMD_POKE &&
        cnt_r == 4'h7)
      mem_r[widx(addr_r)] <= {rx_b, data_r[31:8]};
    if (state_r == LDH_LOAD && rx_hit)
      mem_r[widx(load_ptr_r)][8*load_ptr_r[1:0] +: 8] <= rx_b;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lnk.fault_out <= 1'b0;
      running <= 1'b0;
      refresh_on <= 1'b0;
    end else begin
      lnk.fault_out <= fault_r | err_s_r[1];
      running <= (state_r == LDH_RUN);
      refresh_on <= (cfg_r != 32'h0);
    end
  end
  assign lnk.rx_ready = rdy_r;
  assign lnk.tx_valid = txv_r;
  always_comb begin
    for (int i = 0; i < 4; i++) lnk.tx_byte[i] = txb_r;
  end
  assign lnk.halted = (state_r == LDH_HALTED);
  assign lnk.links_idle = (txv_r == 4'h0) && (state_r != LDH_HALTING);
  assign stop_on_fault_flag = stop_r;
  assign fault_flag = fault_r;
endmodule : ldh_device

// ==== rtl/ldh_host.sv ====
module ldh_host (
  input wire logic pclk,
  input wire logic presetn,
  ldh_if.host lnk,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  typedef enum logic [1:0] {LDH_IDLE, LDH_TX, LDH_RX} ldh_hst_e;
  ldh_hst_e st_r;
  logic [31:0] ctrl_r, addr_r, wdata_r, rdata_r;
  logic [71:0] shift_r;
  logic [3:0] left_r, got_r;
  logic [1:0] sel_r;
  logic busy_r, txv_r;
  logic [1:0] h_s_r, i_s_r;
  logic acc;

  assign acc = psel & penable;

  // Sync of device status pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_s_r <= 2'h0;
      i_s_r <= 2'h0;
    end else begin
      h_s_r <= {h_s_r[0], lnk.halted};
      i_s_r <= {i_s_r[0], lnk.links_idle};
    end
  end

  // APB slave, one wait-free access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 32'h0;
      addr_r <= 32'h0;
      wdata_r <= 32'h0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (st_r != LDH_IDLE) ctrl_r[ldh_pkg::CTRL_GO_BIT] <= 1'b0;
      if (psel && !penable) begin
        unique case (paddr)
          ldh_pkg::REG_CTRL: prdata <= ctrl_r;
          ldh_pkg::REG_ADDR: prdata <= addr_r;
          ldh_pkg::REG_WDATA: prdata <= wdata_r;
          ldh_pkg::REG_RDATA: prdata <= rdata_r;
          ldh_pkg::REG_STATUS: prdata <= {28'h0, i_s_r[1], h_s_r[1],
                                          lnk.fault_out, busy_r};
          default: begin
            prdata <= 32'h0;
            pslverr <= 1'b1;
          end
        endcase
      end
      if (acc && pready && pwrite) begin
        unique case (paddr)
          ldh_pkg::REG_CTRL: ctrl_r <= pwdata;
          ldh_pkg::REG_ADDR: addr_r <= pwdata;
          ldh_pkg::REG_WDATA: wdata_r <= pwdata;
          default: ;
        endcase
      end
    end
  end

  // Link engine: command byte then words LSB first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= LDH_IDLE;
      shift_r <= 72'h0;
      left_r <= 4'h0;
      got_r <= 4'h0;
      sel_r <= 2'h0;
      busy_r <= 1'b0;
      txv_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      unique case (st_r)
        LDH_IDLE: if (ctrl_r[ldh_pkg::CTRL_GO_BIT]) begin
          busy_r <= 1'b1;
          sel_r <= ctrl_r[ldh_pkg::CTRL_LINK_LO +: 2];
          st_r <= LDH_TX;
          txv_r <= 1'b1;
          unique case (ctrl_r[ldh_pkg::CTRL_KIND_LO +: 2])
            ldh_pkg::KIND_POKE: begin
              shift_r <= {wdata_r, addr_r, ldh_pkg::CMD_POKE};
              left_r <= 4'h9;
            end
            ldh_pkg::KIND_PEEK: begin
              shift_r <= {32'h0, addr_r, ldh_pkg::CMD_PEEK};
              left_r <= 4'h5;
            end
            default: begin
              // Length byte then program bytes from ADDR, WDATA; max 8
              shift_r <= {wdata_r, addr_r,
                          ctrl_r[ldh_pkg::CTRL_LOADLEN_LO +: 8]};
              left_r <= 4'h1 + ctrl_r[ldh_pkg::CTRL_LOADLEN_LO +: 4];
            end
          endcase
        end
        LDH_TX: if (lnk.rx_ready[sel_r]) begin
          shift_r <= {8'h00, shift_r[71:8]};
          left_r <= left_r - 4'h1;
          if (left_r == 4'h1) begin
            txv_r <= 1'b0;
            got_r <= 4'h0;
            if (ctrl_r[ldh_pkg::CTRL_KIND_LO +: 2] == ldh_pkg::KIND_PEEK)
              st_r <= LDH_RX;
            else begin
              st_r <= LDH_IDLE;
              busy_r <= 1'b0;
            end
          end
        end
        LDH_RX: if (lnk.tx_valid[sel_r]) begin
          rdata_r <= {lnk.tx_byte[sel_r], rdata_r[31:8]};
          got_r <= got_r + 4'h1;
          if (got_r == 4'h3) begin
            st_r <= LDH_IDLE;
            busy_r <= 1'b0;
          end
        end
        default: st_r <= LDH_IDLE;
      endcase
    end
  end

  // Link and board pin drive
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lnk.rx_valid[i] = txv_r && (sel_r == 2'(i));
      lnk.rx_byte[i] = shift_r[7:0];
      lnk.tx_ready[i] = (st_r == LDH_RX) && (sel_r == 2'(i));
    end
  end
  assign lnk.proc_reset = ctrl_r[ldh_pkg::CTRL_RST_BIT];
  assign lnk.inspect_halt = ctrl_r[ldh_pkg::CTRL_HALT_BIT];
  assign lnk.boot_source_select = ctrl_r[ldh_pkg::CTRL_BOOTSEL_BIT];
  assign lnk.chained_fault_input = ctrl_r[ldh_pkg::CTRL_CHAIN_BIT];
endmodule : ldh_host

// ==== verif/ldh_props.sv ====
// ----
// Interface checks
// ----
module ldh_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] rx_valid,
  input wire logic [3:0] rx_ready,
  input wire logic [3:0] tx_valid,
  input wire logic proc_reset,
  input wire logic inspect_halt,
  input wire logic halted,
  input wire logic links_idle
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_rx_one;
    |rx_valid |-> $onehot(rx_valid);
  endproperty
  a_rx_one: assert property (p_rx_one)
    else $error("bytes offered on two links");
  property p_rx_hold;
    rx_valid[0] && !rx_ready[0] |=> rx_valid[0];
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("byte withdrawn before taken");
  property p_tx_one;
    |tx_valid |-> $onehot(tx_valid);
  endproperty
  a_tx_one: assert property (p_tx_one)
    else $error("answer on two links");
  property p_halt_bound;
    $rose(inspect_halt) && !halted |-> ##[1:400] halted;
  endproperty
  a_halt_bound: assert property (p_halt_bound)
    else $error("no halt after inspection request");
  property p_halt_hold;
    $rose(halted) |=> halted [*4];
  endproperty
  a_halt_hold: assert property (p_halt_hold)
    else $error("halt not held");
  property p_drain;
    $rose(halted) |-> ##[0:300] links_idle;
  endproperty
  a_drain: assert property (p_drain)
    else $error("links still busy after halt");
  property p_no_new_tx;
    halted ##1 halted |-> !$rose(|tx_valid);
  endproperty
  a_no_new_tx: assert property (p_no_new_tx)
    else $error("new byte sent while halted");
  property p_rst_after_halt;
    $rose(proc_reset) |-> halted || !inspect_halt;
  endproperty
  a_rst_after_halt: assert property (p_rst_after_halt)
    else $error("reset raised before halt");
endmodule : ldh_props

// ==== verif/ldh_tb_top.sv ====
`define CHK(a, b) \
  begin \
    comparisons++; \
    if ((a) !== (b)) begin \
      n_errors++; \
      $display("wrong value at %0t: %h expected %h", $time, a, b); \
    end \
  end

module ldh_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic set_stop_on_fault, test_clear, preempt_begin, preempt_end;
  logic deschedule, running, stop_on_fault_flag, fault_flag, refresh_on;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, iptr, wptr, areg, breg, creg, rd;
  logic [4:0] fault_events;
  logic [5:0] memcfg_count;
  logic [7:0] rxq [$];
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  ldh_if ldh_if_i ();
  ldh_device ldh_device_i (.pclk(pclk), .presetn(presetn), .lnk(ldh_if_i),
    .fault_events(fault_events), .set_stop_on_fault(set_stop_on_fault),
    .test_clear(test_clear), .preempt_begin(preempt_begin),
    .preempt_end(preempt_end), .deschedule(deschedule), .running(running),
    .stop_on_fault_flag(stop_on_fault_flag), .fault_flag(fault_flag),
    .iptr(iptr), .wptr(wptr), .areg(areg), .breg(breg), .creg(creg),
    .memcfg_count(memcfg_count), .refresh_on(refresh_on));
  ldh_host ldh_host_i (.pclk(pclk), .presetn(presetn), .lnk(ldh_if_i),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ldh_props ldh_props_i (.pclk(pclk), .presetn(presetn),
    .rx_valid(ldh_if_i.rx_valid), .rx_ready(ldh_if_i.rx_ready),
    .tx_valid(ldh_if_i.tx_valid), .proc_reset(ldh_if_i.proc_reset),
    .inspect_halt(ldh_if_i.inspect_halt), .halted(ldh_if_i.halted),
    .links_idle(ldh_if_i.links_idle));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Records every byte taken by the device, any link
  always @(posedge pclk) begin
    for (int k = 0; k < 4; k++) begin
      if (ldh_if_i.rx_valid[k] && ldh_if_i.rx_ready[k]) begin
        rxq.push_back(ldh_if_i.rx_byte[k]);
      end
    end
  end

  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 80000) begin
      n_errors++;
      give_verdict();
    end
  end

  // ----
  // Bus and event tasks
  // ----
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (pready !== 1'b1) n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wctl(logic [2:0] lvl, logic go = 1'b0,
      logic [1:0] kind = 2'h0, logic [1:0] l = 2'h0, logic [7:0] n = 8'h0);
    apb(1'b1, ldh_pkg::REG_CTRL, {16'h0, n, lvl, l, kind, go});
  endtask : wctl

  task automatic idle_wait();
    int t;
    t = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0 && t < 2000) begin
      apb(1'b0, ldh_pkg::REG_STATUS, 32'h0);
      t++;
    end
    if (rd[0] !== 1'b0) n_errors++;
  endtask : idle_wait

  task automatic poke(logic [1:0] l, logic [31:0] a, logic [31:0] d);
    apb(1'b1, ldh_pkg::REG_ADDR, a);
    apb(1'b1, ldh_pkg::REG_WDATA, d);
    wctl(3'h0, 1'b1, ldh_pkg::KIND_POKE, l);
    idle_wait();
  endtask : poke

  task automatic peek(logic [1:0] l, logic [31:0] a);
    apb(1'b1, ldh_pkg::REG_ADDR, a);
    wctl(3'h0, 1'b1, ldh_pkg::KIND_PEEK, l);
    idle_wait();
    apb(1'b0, ldh_pkg::REG_RDATA, 32'h0);
  endtask : peek

  // Bits: faults[9:5], stop, clear, preempt in, preempt out, deschedule
  task automatic ev(logic [9:0] v);
    {fault_events, set_stop_on_fault, test_clear, preempt_begin,
      preempt_end, deschedule} <= v;
    @(posedge pclk);
    {fault_events, set_stop_on_fault, test_clear, preempt_begin,
      preempt_end, deschedule} <= 10'h0;
    repeat (3) @(posedge pclk);
  endtask : ev

  // ----
  // Scenarios
  // ----
  task automatic t_peek_poke();
    rxq.delete();
    poke(2'h1, 32'h80000100, 32'ha1b2c3d4);
    `CHK(rxq.size(), 9);
    `CHK(rxq[0], ldh_pkg::CMD_POKE);
    `CHK(rxq[1], 8'h00);
    `CHK(rxq[8], 8'ha1);
    poke(2'h1, 32'h80000104, 32'h0badf00d);
    peek(2'h2, 32'h80000100);
    `CHK(rd, 32'ha1b2c3d4);
    peek(2'h3, 32'h80000104);
    `CHK(rd, 32'h0badf00d);
    apb(1'b0, 8'h14, 32'h0);
    `CHK(err, 1'b1);
  endtask : t_peek_poke

  task automatic t_load();
    int t;
    t = 0;
    rxq.delete();
    wctl(3'h0, 1'b1, ldh_pkg::KIND_LOAD, 2'h0, 8'h04);
    while (running !== 1'b1 && t < 500) begin
      @(posedge pclk);
      t++;
    end
    `CHK(rxq[0], 8'h04);
    `CHK(rxq.size(), 5);
    `CHK(running, 1'b1);
  endtask : t_load

  task automatic t_flags();
    for (int i = 0; i < 5; i++) begin
      ev({5'h01 << i, 5'h00});
      `CHK(fault_flag, 1'b1);
      apb(1'b0, ldh_pkg::REG_STATUS, 32'h0);
      `CHK(rd[1], 1'b1);
      ev(10'h008);
      `CHK(fault_flag, 1'b0);
    end
    apb(1'b1, ldh_pkg::REG_CTRL, 32'h00010000);
    repeat (6) @(posedge pclk);
    apb(1'b0, ldh_pkg::REG_STATUS, 32'h0);
    `CHK(rd[1], 1'b1);
    `CHK(fault_flag, 1'b0);
    apb(1'b1, ldh_pkg::REG_CTRL, 32'h0);
    repeat (6) @(posedge pclk);
    apb(1'b0, ldh_pkg::REG_STATUS, 32'h0);
    `CHK(rd[1], 1'b0);
    ev(10'h004);
    ev(10'h020);
    `CHK(fault_flag, 1'b1);
    ev(10'h002);
    `CHK(fault_flag, 1'b0);
    ev(10'h020);
    ev(10'h010);
    `CHK(running, 1'b1);
    ev(10'h008);
    `CHK(stop_on_fault_flag, 1'b1);
  endtask : t_flags

  task automatic t_inspect(logic b);
    logic [31:0] ip;
    logic sf;
    logic [5:0] mc;
    int t;
    t = 0;
    wctl({b, 2'b01});
    rd = 32'h0;
    while (rd[2] !== 1'b1 && t < 100) begin
      ev(10'h001);
      apb(1'b0, ldh_pkg::REG_STATUS, 32'h0);
      t++;
    end
    if (rd[2] !== 1'b1) n_errors++;
    `CHK(running, 1'b0);
    `CHK(areg, iptr);
    ip = iptr;
    sf = stop_on_fault_flag;
    mc = memcfg_count;
    wctl({b, 2'b11});
    repeat (5) @(posedge pclk);
    wctl({b, 2'b01});
    repeat (80) @(posedge pclk);
    `CHK(memcfg_count, mc);
    `CHK(stop_on_fault_flag, sf);
    `CHK(areg, ip);
    wctl({b, 2'b00});
    repeat (20) @(posedge pclk);
    if (b) begin
      `CHK(running, 1'b1);
      `CHK(iptr, ldh_pkg::ROM_BOOT_ADDR);
      `CHK(wptr, ldh_pkg::USER_MEMORY_BASE);
    end else begin
      `CHK(running, 1'b0);
      peek(2'h0, 32'h80000100);
      `CHK(rd, 32'ha1b2c3d4);
    end
  endtask : t_inspect

  task automatic t_fault_halt();
    ev(10'h200);
    repeat (20) @(posedge pclk);
    `CHK(running, 1'b0);
    `CHK(areg, iptr);
  endtask : t_fault_halt

  task automatic give_verdict();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {fault_events, set_stop_on_fault, test_clear, preempt_begin,
      preempt_end, deschedule} = 10'h0;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (60) @(posedge pclk);
    t_peek_poke();
    t_load();
    t_flags();
    t_inspect(1'b0);
    t_load();
    t_inspect(1'b1);
    t_fault_halt();
    give_verdict();
  end
endmodule : ldh_tb_top
